// ==== logic/ipcb_bridge.sv ====
// PIO cycle bridge from a PCI target request port to the IDE drive pins
`timescale 1ns/1ps
`default_nettype none
`include "ipcb_consts.svh"

module ipcb_bridge (
   input wire logic i_clock,
   input wire logic i_srst,
   input wire logic i_req_valid,
   input wire logic i_req_write,
   input wire logic i_req_post,
   input wire logic i_req_bm_read,
   input wire logic [15:2] i_req_addr,
   input wire logic [3:0] i_req_be,
   input wire logic [31:0] i_req_wdata,
   input wire logic [15:0] i_ra_words,
   output logic o_req_ack,
   output logic o_req_retry,
   output logic [31:0] o_req_rdata,
   output logic o_ra_active,
   output logic o_ide_sec,
   output logic o_ide_cs0_n,
   output logic o_ide_cs1_n,
   output logic [2:0] o_ide_addr,
   output logic o_ide_rd_n,
   output logic o_ide_wr_n,
   output logic [15:0] o_ide_dout,
   output logic o_ide_doe,
   input wire logic [15:0] i_ide_din
);
   function automatic logic [1:0] first_lane(input logic [3:0] be);
      logic [1:0] l;
      l = 2'h3;
      if (be[0]) begin
         l = 2'h0;
      end else if (be[1]) begin
         l = 2'h1;
      end else if (be[2]) begin
         l = 2'h2;
      end
      return l;
   endfunction : first_lane

   function automatic logic [2:0] nbytes(input logic [3:0] be);
      return {2'h0, be[0]} + {2'h0, be[1]} + {2'h0, be[2]} + {2'h0, be[3]};
   endfunction : nbytes

   function automatic ipcb_pkg::ipcb_dec_t decode(input logic [15:0] ba);
      ipcb_pkg::ipcb_dec_t d;
      d = '0;
      if ({ba[15:3], 3'h0} == `IPCB_PRI_CMD) begin
         d.hit = 1'b1;
         d.reg_ix = ba[2:0];
      end else if ({ba[15:3], 3'h0} == `IPCB_SEC_CMD) begin
         d.hit = 1'b1;
         d.sec = 1'b1;
         d.reg_ix = ba[2:0];
      end else if (ba == `IPCB_PRI_CTL || ba == `IPCB_SEC_CTL) begin
         d.hit = 1'b1;
         d.sec = (ba == `IPCB_SEC_CTL);
         d.ctl = 1'b1;
         d.reg_ix = `IPCB_ALT_REG;
      end
      return d;
   endfunction : decode

   ipcb_pkg::ipcb_estate_t estate;
   ipcb_pkg::ipcb_src_t op_src;
   ipcb_pkg::ipcb_src_t ld_src;
   ipcb_pkg::ipcb_dec_t dec;
   logic is_data;
   logic [1:0] nwd;
   logic [2:0] hn_c;
   logic eng_idle;
   logic ans_q;
   logic c_retry;
   logic c_ack;
   logic c_push;
   logic c_kill;
   logic c_ra_start;
   logic c_ra_pop;
   logic c_host_go;
   logic ld_go;
   logic ld_write;
   logic ld_sec;
   logic ld_ctl;
   logic [2:0] ld_addr;
   logic [15:0] ld_dout;
   logic [1:0] ld_k;
   logic [1:0] ld_lane;
   logic [7:0] ecnt;
   logic op_write;
   logic [1:0] op_lane;
   logic hop_busy;
   logic [1:0] hk;
   logic [2:0] hn;
   logic host_done;
   logic ra_push;
   logic [15:0] ra_word;
   logic [31:0] rd_pipe;
   logic [15:0] din_s;
   logic [16:0] wf_dout;
   logic [2:0] wf_count;
   logic [2:0] wf_free;
   logic wf_empty;
   logic wf_pop;
   logic [15:0] ra_buf [4];
   logic [1:0] ra_wp;
   logic [1:0] ra_rp;
   logic [2:0] ra_cnt;
   logic [15:0] ra_left;
   logic ra_sec;
   logic o_ide_rd_n_q;
   logic o_ide_wr_n_q;

   ipcb_sync u_sync (
      .i_clock(i_clock),
      .i_srst(i_srst),
      .i_async(i_ide_din),
      .o_sync(din_s)
   );

   ipcb_wfifo u_wfifo (
      .i_clock(i_clock),
      .i_srst(i_srst),
      .i_push(c_push),
      .i_two(nwd == 2'h2),
      .i_data0({dec.sec, i_req_wdata[15:0]}),
      .i_data1({dec.sec, i_req_wdata[31:16]}),
      .i_pop(wf_pop),
      .o_data(wf_dout),
      .o_count(wf_count),
      .o_empty(wf_empty)
   );

   assign dec = decode({i_req_addr, first_lane(i_req_be)});
   assign is_data = dec.hit && !dec.ctl && (dec.reg_ix == `IPCB_DATA_REG);
   assign nwd = (i_req_be[3:2] != 2'h0) ? 2'h2 : 2'h1;
   assign hn_c = is_data ? {1'b0, nwd} : nbytes(i_req_be);
   assign eng_idle = (estate == ipcb_pkg::E_IDLE);
   assign ans_q = o_req_ack | o_req_retry;
   assign wf_free = `IPCB_WF_DEPTH - wf_count;
   assign wf_pop = eng_idle && !wf_empty;
   assign o_ide_rd_n = o_ide_rd_n_q;
   assign o_ide_wr_n = o_ide_wr_n_q;

   // Request decision; a held request is looked at once per answer
   always_comb begin
      c_retry = 1'b0;
      c_ack = 1'b0;
      c_push = 1'b0;
      c_kill = 1'b0;
      c_ra_start = 1'b0;
      c_ra_pop = 1'b0;
      c_host_go = 1'b0;
      if (i_req_valid && !ans_q && !hop_busy && !host_done) begin
         if (i_req_bm_read && !i_req_write) begin
            c_retry = 1'b1;
         end else if (!dec.hit || i_req_be == 4'h0) begin
            c_ack = 1'b1;
         end else if (i_req_write && i_req_post && is_data) begin
            c_kill = 1'b1;
            if (wf_free >= {1'b0, nwd}) begin
               c_push = 1'b1;
               c_ack = 1'b1;
            end else begin
               c_retry = 1'b1;
            end
         end else if (!wf_empty) begin
            c_retry = 1'b1;
         end else if (!i_req_write && is_data) begin
            if (ra_cnt >= {1'b0, nwd}) begin
               c_ra_pop = 1'b1;
               c_ack = 1'b1;
            end else if (!o_ra_active && eng_idle) begin
               c_ra_start = 1'b1;
            end
         end else if (eng_idle) begin
            c_host_go = 1'b1;
            c_kill = 1'b1;
         end
      end
   end

   // Next drive cycle: FIFO first, then host, then read-ahead
   always_comb begin
      ld_go = 1'b0;
      ld_src = ipcb_pkg::SRC_FIFO;
      ld_write = 1'b0;
      ld_sec = 1'b0;
      ld_ctl = 1'b0;
      ld_addr = `IPCB_DATA_REG;
      ld_dout = wf_dout[15:0];
      ld_k = c_host_go ? 2'h0 : hk;
      ld_lane = first_lane(i_req_be) + ld_k;
      if (eng_idle) begin
         if (!wf_empty) begin
            ld_go = 1'b1;
            ld_write = 1'b1;
            ld_sec = wf_dout[16];
         end else if (c_host_go || hop_busy) begin
            ld_go = 1'b1;
            ld_src = ipcb_pkg::SRC_HOST;
            ld_write = i_req_write;
            ld_sec = dec.sec;
            ld_ctl = dec.ctl;
            if (is_data) begin
               ld_dout = ld_k[0] ? i_req_wdata[31:16] : i_req_wdata[15:0];
            end else begin
               ld_addr = dec.reg_ix + {1'b0, ld_k};
               ld_dout = {8'h00, i_req_wdata[{ld_lane, 3'h0} +: 8]};
            end
         end else if (o_ra_active && ra_cnt < `IPCB_RA_DEPTH) begin
            ld_go = 1'b1;
            ld_src = ipcb_pkg::SRC_RA;
            ld_sec = ra_sec;
         end
      end
   end

   // Drive cycle timing: address setup, strobe, recovery before the next
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         estate <= ipcb_pkg::E_IDLE;
         ecnt <= 8'h00;
         op_src <= ipcb_pkg::SRC_FIFO;
         op_write <= 1'b0;
         op_lane <= 2'h0;
         hop_busy <= 1'b0;
         hk <= 2'h0;
         hn <= 3'h0;
         host_done <= 1'b0;
         ra_push <= 1'b0;
         ra_word <= 16'h0000;
         rd_pipe <= 32'h0000_0000;
         o_ide_sec <= 1'b0;
         o_ide_cs0_n <= 1'b1;
         o_ide_cs1_n <= 1'b1;
         o_ide_addr <= 3'h0;
         o_ide_rd_n_q <= 1'b1;
         o_ide_wr_n_q <= 1'b1;
         o_ide_dout <= 16'h0000;
         o_ide_doe <= 1'b0;
      end else begin
         host_done <= 1'b0;
         ra_push <= 1'b0;
         unique case (estate)
            ipcb_pkg::E_IDLE: begin
               if (c_host_go) begin
                  hop_busy <= 1'b1;
                  hk <= 2'h0;
                  hn <= hn_c;
                  rd_pipe <= 32'h0000_0000;
               end
               if (ld_go) begin
                  estate <= ipcb_pkg::E_SETUP;
                  ecnt <= 8'h00;
                  op_src <= ld_src;
                  op_write <= ld_write;
                  op_lane <= ld_lane;
                  o_ide_sec <= ld_sec;
                  o_ide_addr <= ld_addr;
                  o_ide_cs0_n <= ld_ctl;
                  o_ide_cs1_n <= !ld_ctl;
                  o_ide_dout <= ld_dout;
                  o_ide_doe <= ld_write;
               end
            end
            ipcb_pkg::E_SETUP: begin
               if (ecnt == 8'(`IPCB_SETUP_CYC - 1)) begin
                  estate <= ipcb_pkg::E_STROBE;
                  ecnt <= 8'h00;
                  o_ide_wr_n_q <= !op_write;
                  o_ide_rd_n_q <= op_write;
               end else begin
                  ecnt <= ecnt + 8'h01;
               end
            end
            ipcb_pkg::E_STROBE: begin
               if (ecnt == 8'(`IPCB_STROBE_CYC - 1)) begin
                  estate <= ipcb_pkg::E_RECOV;
                  ecnt <= 8'h00;
                  o_ide_wr_n_q <= 1'b1;
                  o_ide_rd_n_q <= 1'b1;
                  if (!op_write && op_src == ipcb_pkg::SRC_RA) begin
                     ra_push <= 1'b1;
                     ra_word <= din_s;
                  end else if (!op_write) begin
                     rd_pipe[{op_lane, 3'h0} +: 8] <= din_s[7:0];
                  end
                  if (op_src == ipcb_pkg::SRC_HOST) begin
                     if ({1'b0, hk} == hn - 3'h1) begin
                        hop_busy <= 1'b0;
                        host_done <= 1'b1;
                     end else begin
                        hk <= hk + 2'h1;
                     end
                  end
               end else begin
                  ecnt <= ecnt + 8'h01;
               end
            end
            ipcb_pkg::E_RECOV: begin
               if (ecnt == 8'(`IPCB_RECOV_CYC - 1)) begin
                  estate <= ipcb_pkg::E_IDLE;
                  o_ide_cs0_n <= 1'b1;
                  o_ide_cs1_n <= 1'b1;
                  o_ide_doe <= 1'b0;
               end else begin
                  ecnt <= ecnt + 8'h01;
               end
            end
         endcase
      end
   end

   // Read-ahead control and word count
   always_ff @(posedge i_clock) begin
      if (i_srst || c_kill) begin
         o_ra_active <= 1'b0;
         ra_left <= 16'h0000;
         ra_wp <= 2'h0;
         ra_rp <= 2'h0;
         ra_cnt <= 3'h0;
         ra_sec <= 1'b0;
      end else begin
         if (c_ra_start) begin
            o_ra_active <= 1'b1;
            ra_sec <= dec.sec;
            ra_left <= (i_ra_words == 16'h0000) ? 16'h0001 : i_ra_words;
         end else if (ra_push && o_ra_active) begin
            ra_left <= ra_left - 16'h0001;
            if (ra_left == 16'h0001) begin
               o_ra_active <= 1'b0;
            end
         end
         if (ra_push && o_ra_active) begin
            ra_wp <= ra_wp + 2'h1;
         end
         if (c_ra_pop) begin
            ra_rp <= ra_rp + nwd;
         end
         ra_cnt <= ra_cnt + {2'h0, ra_push && o_ra_active} - (c_ra_pop ? {1'b0, nwd} : 3'h0);
      end
   end

   always_ff @(posedge i_clock) begin
      if (ra_push && o_ra_active) begin
         ra_buf[ra_wp] <= ra_word;
      end
   end

   // Answers toward the PCI target
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_req_ack <= 1'b0;
         o_req_retry <= 1'b0;
         o_req_rdata <= 32'h0000_0000;
      end else begin
         o_req_ack <= c_ack | host_done;
         o_req_retry <= c_retry;
         if (c_ra_pop) begin
            o_req_rdata <= (nwd == 2'h2) ? {ra_buf[ra_rp + 2'h1], ra_buf[ra_rp]}
                                         : {16'h0000, ra_buf[ra_rp]};
         end else if (host_done) begin
            o_req_rdata <= rd_pipe;
         end else if (c_ack) begin
            o_req_rdata <= 32'h0000_0000;
         end
      end
   end
endmodule : ipcb_bridge
`default_nettype wire

// ==== inc/ipcb_consts.svh ====
// Address map, depths and drive timing constants of the PIO cycle bridge
`ifndef IPCB_CONSTS_SVH
`define IPCB_CONSTS_SVH

`define IPCB_CLK_MHZ 50
`define IPCB_SETUP_NS 30
`define IPCB_STROBE_NS 165
`define IPCB_RECOV_NS 70
`define IPCB_SETUP_CYC (((`IPCB_SETUP_NS * `IPCB_CLK_MHZ) + 999) / 1000)
`define IPCB_STROBE_CYC (((`IPCB_STROBE_NS * `IPCB_CLK_MHZ) + 999) / 1000)
`define IPCB_RECOV_CYC (((`IPCB_RECOV_NS * `IPCB_CLK_MHZ) + 999) / 1000)

`define IPCB_PRI_CMD 16'h01F0
`define IPCB_SEC_CMD 16'h0170
`define IPCB_PRI_CTL 16'h03F6
`define IPCB_SEC_CTL 16'h0376
`define IPCB_DATA_REG 3'h0
`define IPCB_ALT_REG 3'h6

`define IPCB_WF_DEPTH 3'h4
`define IPCB_RA_DEPTH 3'h4

`endif

// ==== inc/ipcb_pkg.sv ====
// Types shared by the PIO cycle bridge
`default_nettype none
package ipcb_pkg;
   typedef enum logic [3:0] {
      E_IDLE = 4'b0001,
      E_SETUP = 4'b0010,
      E_STROBE = 4'b0100,
      E_RECOV = 4'b1000
   } ipcb_estate_t;

   typedef enum logic [2:0] {
      SRC_FIFO = 3'b001,
      SRC_HOST = 3'b010,
      SRC_RA = 3'b100
   } ipcb_src_t;

   typedef struct packed {
      logic hit;
      logic sec;
      logic ctl;
      logic [2:0] reg_ix;
   } ipcb_dec_t;
endpackage : ipcb_pkg
`default_nettype wire

// ==== logic/ipcb_sync.sv ====
// Three-stage input synchroniser for the drive data pins
`timescale 1ns/1ps
`default_nettype none
module ipcb_sync (
   input wire logic i_clock,
   input wire logic i_srst,
   input wire logic [15:0] i_async,
   output logic [15:0] o_sync
);
   logic [15:0] s1;
   logic [15:0] s2;
   logic [15:0] s3;

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         s1 <= 16'h0000;
         s2 <= 16'h0000;
         s3 <= 16'h0000;
         o_sync <= 16'h0000;
      end else begin
         s1 <= i_async;
         s2 <= s1;
         s3 <= s2;
         // A change counts once stages two and three agree
         if (s2 == s3) begin
            o_sync <= s3;
         end
      end
   end
endmodule : ipcb_sync
`default_nettype wire

// ==== logic/ipcb_wfifo.sv ====
// Posted write FIFO, one or two entries pushed per cycle
`timescale 1ns/1ps
`default_nettype none
`include "ipcb_consts.svh"
module ipcb_wfifo (
   input wire logic i_clock,
   input wire logic i_srst,
   input wire logic i_push,
   input wire logic i_two,
   input wire logic [16:0] i_data0,
   input wire logic [16:0] i_data1,
   input wire logic i_pop,
   output logic [16:0] o_data,
   output logic [2:0] o_count,
   output logic o_empty
);
   logic [16:0] mem [4];
   logic [1:0] wp;
   logic [1:0] rp;

   always_ff @(posedge i_clock) begin
      if (i_push) begin
         mem[wp] <= i_data0;
         if (i_two) begin
            mem[wp + 2'h1] <= i_data1;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         wp <= 2'h0;
         rp <= 2'h0;
         o_count <= 3'h0;
      end else begin
         if (i_push) begin
            wp <= wp + (i_two ? 2'h2 : 2'h1);
         end
         if (i_pop) begin
            rp <= rp + 2'h1;
         end
         o_count <= o_count + (i_push ? (i_two ? 3'h2 : 3'h1) : 3'h0) - {2'h0, i_pop};
      end
   end

   assign o_data = mem[rp];
   assign o_empty = (o_count == 3'h0);
endmodule : ipcb_wfifo
`default_nettype wire

// ==== verification/ipcb_drive_model.sv ====
// Behavioural drive on the cable: task file, status and a counting data port
`timescale 1ns/1ps
`default_nettype none
module ipcb_drive_model #(
   parameter logic [7:0] STATUS = 8'h50,
   parameter logic [15:0] FIRST_WORD = 16'hA000
) (
   input wire logic i_cs0_n,
   input wire logic i_cs1_n,
   input wire logic [2:0] i_addr,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   input wire logic [15:0] i_dout,
   output logic [15:0] o_din
);
   logic [7:0] task_reg [8];
   logic [7:0] dev_ctl = 8'h00;
   logic [15:0] word = FIRST_WORD;
   logic [15:0] held = 16'h0000;
   logic [15:0] value;
   always_comb begin
      if (!i_cs1_n) begin
         value = {8'h00, STATUS};
      end else if (i_addr == 3'h0) begin
         value = word;
      end else if (i_addr == 3'h7) begin
         value = {8'h00, STATUS};
      end else begin
         value = {8'h00, task_reg[i_addr]};
      end
   end
   // Released bus shows the inverse of the last word, never a stale copy
   assign o_din = i_rd_n ? ~held : value;
   always @(posedge i_rd_n) begin
      held <= value;
      if (!i_cs0_n && i_addr == 3'h0) word <= word + 16'h0001;
   end
   always @(posedge i_wr_n) begin
      if (!i_cs1_n) dev_ctl <= i_dout[7:0];
      else if (!i_cs0_n) task_reg[i_addr] <= i_dout[7:0];
   end
endmodule : ipcb_drive_model
`default_nettype wire

// ==== verification/ipcb_bridge_monitor.sv ====
// Assertion checker on the ports of the PIO cycle bridge
`timescale 1ns/1ps
`default_nettype none
module ipcb_bridge_monitor (
   input wire logic i_clock,
   input wire logic i_srst,
   input wire logic i_req_valid,
   input wire logic i_req_write,
   input wire logic i_req_bm_read,
   input wire logic o_req_ack,
   input wire logic o_ide_cs0_n,
   input wire logic o_ide_cs1_n,
   input wire logic [2:0] o_ide_addr,
   input wire logic o_ide_rd_n,
   input wire logic o_ide_wr_n,
   input wire logic [15:0] o_ide_dout,
   input wire logic o_ide_doe
);
   logic sel;
   assign sel = !o_ide_cs0_n || !o_ide_cs1_n;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_srst);
   sequence s_wr_pulse;
      (!o_ide_wr_n) [*8] ##1 o_ide_wr_n;
   endsequence
   sequence s_rd_pulse;
      (!o_ide_rd_n) [*8] ##1 o_ide_rd_n;
   endsequence
   sequence s_quiet;
      (o_ide_rd_n && o_ide_wr_n) [*4];
   endsequence
   a_wr_setup: assert property ($fell(o_ide_wr_n) |-> $past(sel, 2))
      else $error("write strobe without address setup");
   a_wr_width: assert property ($fell(o_ide_wr_n) |=> s_wr_pulse)
      else $error("write strobe width wrong");
   a_rd_setup: assert property ($fell(o_ide_rd_n) |-> $past(sel, 2))
      else $error("read strobe without address setup");
   a_rd_width: assert property ($fell(o_ide_rd_n) |=> s_rd_pulse)
      else $error("read strobe width wrong");
   a_strobe_recover: assert property ($rose(o_ide_rd_n) || $rose(o_ide_wr_n) |=> s_quiet)
      else $error("strobe precharge too short");
   a_cs_single: assert property (o_ide_cs0_n || o_ide_cs1_n)
      else $error("both selects active");
   a_alt_addr: assert property (!o_ide_cs1_n |-> o_ide_addr == 3'h6)
      else $error("control block address wrong");
   a_write_drive: assert property (!o_ide_wr_n |-> o_ide_doe && $stable(o_ide_dout))
      else $error("write data not held");
   a_read_float: assert property (!o_ide_rd_n |-> !o_ide_doe)
      else $error("data driven during read");
   a_bm_no_ack: assert property (i_req_valid && i_req_bm_read && !i_req_write |-> !o_req_ack)
      else $error("bus-master read acknowledged");
endmodule : ipcb_bridge_monitor
bind ipcb_bridge ipcb_bridge_monitor u_mon (
   .i_clock(i_clock), .i_srst(i_srst), .i_req_valid(i_req_valid), .i_req_write(i_req_write),
   .i_req_bm_read(i_req_bm_read), .o_req_ack(o_req_ack), .o_ide_cs0_n(o_ide_cs0_n),
   .o_ide_cs1_n(o_ide_cs1_n), .o_ide_addr(o_ide_addr), .o_ide_rd_n(o_ide_rd_n),
   .o_ide_wr_n(o_ide_wr_n), .o_ide_dout(o_ide_dout), .o_ide_doe(o_ide_doe)
);
`default_nettype wire

// ==== verification/ipcb_bridge_tb_top.sv ====
// Self-checking testbench of the PIO cycle bridge against a drive model
`timescale 1ns/1ps
`default_nettype none
module ipcb_bridge_tb_top;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic valid = 1'b0;
   logic write = 1'b0;
   logic post = 1'b0;
   logic bm = 1'b0;
   logic [15:2] addr = 14'h0000;
   logic [3:0] be = 4'h0;
   logic [31:0] wdata = 32'h00000000;
   logic [15:0] ra_words = 16'h0001;
   logic ack, retry, ra_active, sec, cs0_n, cs1_n, rd_n, wr_n, doe, rt, rsec;
   logic [31:0] rdata, rd;
   logic [2:0] ide_addr;
   logic [15:0] ide_dout, ide_din;
   logic [19:0] wlog[$];
   int bad_count = 0;
   int total_checks = 0;
   int dstrobes = 0;
   always #10 clock = ~clock;
   ipcb_bridge DUT (
      .i_clock(clock), .i_srst(srst), .i_req_valid(valid), .i_req_write(write),
      .i_req_post(post), .i_req_bm_read(bm), .i_req_addr(addr), .i_req_be(be),
      .i_req_wdata(wdata), .i_ra_words(ra_words), .o_req_ack(ack), .o_req_retry(retry),
      .o_req_rdata(rdata), .o_ra_active(ra_active), .o_ide_sec(sec), .o_ide_cs0_n(cs0_n),
      .o_ide_cs1_n(cs1_n), .o_ide_addr(ide_addr), .o_ide_rd_n(rd_n), .o_ide_wr_n(wr_n),
      .o_ide_dout(ide_dout), .o_ide_doe(doe), .i_ide_din(ide_din)
   );
   ipcb_drive_model drive (
      .i_cs0_n(cs0_n), .i_cs1_n(cs1_n), .i_addr(ide_addr), .i_rd_n(rd_n),
      .i_wr_n(wr_n), .i_dout(ide_dout), .o_din(ide_din)
   );
   // Log each drive write as {cs1_n, addr, data} and count data-port reads
   always @(posedge wr_n) if (!srst) wlog.push_back({cs1_n, ide_addr, ide_dout});
   always @(negedge rd_n) begin
      rsec = sec;
      if (!cs0_n && ide_addr == 3'h0) dstrobes++;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   task automatic req(input logic w, input logic p, input logic b, input logic [15:0] a,
      input logic [3:0] e, input logic [31:0] d);
      int n;
      @(negedge clock);
      write = w;
      post = p;
      bm = b;
      addr = a[15:2];
      be = e;
      wdata = d;
      valid = 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (ack !== 1'b1 && retry !== 1'b1 && n < 500);
      rt = retry;
      rd = rdata;
      @(negedge clock);
      valid = 1'b0;
   endtask : req
   task automatic wait_wr(input int n);
      for (int i = 0; i < 2000 && wlog.size() < n; i++) @(posedge clock);
   endtask : wait_wr
   task automatic t_ctl_read;
      req(1'b0, 1'b0, 1'b0, 16'h01F4, 4'h8, 32'h0);
      check(rd[31:24], 8'h50, "status read");
      req(1'b0, 1'b0, 1'b0, 16'h03F4, 4'h4, 32'h0);
      check(rd[23:16], 8'h50, "alternate status");
      req(1'b0, 1'b0, 1'b0, 16'h0174, 4'h8, 32'h0);
      check({rsec, rd[31:24]}, 9'h150, "secondary status");
   endtask : t_ctl_read
   task automatic t_ctl_write;
      logic [3:0] bes [3] = '{4'h4, 4'h3, 4'hF};
      int k;
      for (int i = 0; i < 3; i++) begin
         wlog.delete();
         req(1'b1, 1'b0, 1'b0, 16'h01F4, bes[i], 32'h44332211);
         k = 0;
         for (int j = 0; j < 4; j++) begin
            if (bes[i][j]) begin
               check({wlog[k][19:16], wlog[k][7:0]}, {1'b1, 3'(4 + j), 8'(8'h11 * (j + 1))}, "byte cycle");
               k++;
            end
         end
         check(wlog.size(), k, "byte cycle count");
      end
      wlog.delete();
      req(1'b1, 1'b0, 1'b0, 16'h03F4, 4'h4, 32'h00020000);
      check({wlog[0][19:16], wlog[0][7:0]}, 12'h602, "device control");
   endtask : t_ctl_write
   task automatic t_posted;
      wlog.delete();
      req(1'b1, 1'b1, 1'b0, 16'h01F0, 4'hF, 32'hB2B2A1A1);
      check(rt, 1'b0, "post one");
      req(1'b1, 1'b1, 1'b0, 16'h01F0, 4'hF, 32'hD4D4C3C3);
      check(rt, 1'b0, "post two");
      req(1'b1, 1'b1, 1'b0, 16'h01F0, 4'hF, 32'hF6F6E5E5);
      check(rt, 1'b1, "post into full queue");
      req(1'b0, 1'b0, 1'b0, 16'h01F4, 4'h8, 32'h0);
      check(rt, 1'b1, "read behind writes");
      req(1'b0, 1'b0, 1'b1, 16'h0C00, 4'hF, 32'h0);
      check(rt, 1'b1, "bus-master read");
      wait_wr(4);
      req(1'b1, 1'b1, 1'b0, 16'h01F0, 4'hF, 32'hF6F6E5E5);
      req(1'b1, 1'b1, 1'b0, 16'h01F0, 4'h1, 32'h00007788);
      wait_wr(7);
      req(1'b0, 1'b0, 1'b0, 16'h01F4, 4'h8, 32'h0);
      check(rt, 1'b0, "read after drain");
      check(wlog.size(), 7, "data write count");
      foreach (wlog[i]) begin
         check(wlog[i], (i == 6) ? 20'h87788 : {4'h8, 16'hA1A1 + 16'(i) * 16'h1111}, "data word");
      end
   endtask : t_posted
   task automatic t_readahead;
      int n0;
      n0 = dstrobes;
      ra_words = 16'h0006;
      req(1'b0, 1'b0, 1'b0, 16'h01F0, 4'h3, 32'h0);
      check(rd, {16'h0000, 16'hA000 + 16'(n0)}, "first data word");
      repeat (100) @(posedge clock);
      check(dstrobes - n0 >= 3, 1'b1, "words fetched ahead");
      req(1'b0, 1'b0, 1'b0, 16'h01F0, 4'hF, 32'h0);
      check(rd, {16'hA002 + 16'(n0), 16'hA001 + 16'(n0)}, "dword from buffer");
      repeat (150) @(posedge clock);
      check(dstrobes - n0, 6, "count expiry");
      req(1'b0, 1'b0, 1'b0, 16'h01F4, 4'h8, 32'h0);
      req(1'b0, 1'b0, 1'b0, 16'h01F0, 4'h1, 32'h0);
      check(rd, {16'h0000, 16'hA006 + 16'(n0)}, "fresh word after flush");
      ra_words = 16'h0014;
      repeat (30) @(posedge clock);
      check(ra_active, 1'b1, "read-ahead running");
      req(1'b1, 1'b1, 1'b0, 16'h01F0, 4'h3, 32'h00001234);
      repeat (2) @(posedge clock);
      check(ra_active, 1'b0, "ended by data write");
      repeat (60) @(posedge clock);
   endtask : t_readahead
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done
   initial begin
      repeat (4) @(posedge clock);
      @(negedge clock);
      srst = 1'b0;
      t_ctl_read();
      t_ctl_write();
      t_posted();
      t_readahead();
      test_done();
   end
   initial begin
      repeat (8000) @(posedge clock);
      bad_count++;
      test_done();
   end
endmodule : ipcb_bridge_tb_top
`default_nettype wire
